// ### core_irq_model.sv
// behavioural model of the core interrupt logic facing the router
`timescale 1ns/10ps
module core_irq_model
  import irq_route_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // requests from the router
  input wire logic [NUM_IRQ-1:0] irqToCore,
  // request it would serve first
  output logic [IRQ_NUM_W-1:0] svcNum,
  output logic svcValid
);
  // lowest number wins; keeps the last choice while idle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      svcNum <= 5'h00;
      svcValid <= 1'b0;
    end else begin
      svcValid <= |irqToCore;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
        if (irqToCore[i]) begin
          svcNum <= IRQ_NUM_W'(i);
        end
      end
    end
  end
endmodule : core_irq_model

// ### irq_route_pkg.sv
// shared constants, register map and carrier types for the reset and interrupt router
package irq_route_pkg;

  // line counts and interrupt numbers
  localparam int NUM_PINS = 6;
  localparam int NUM_PERIPH = 12;
  localparam int NUM_IRQ = 18;
  localparam int IRQ_NUM_W = 5;
  localparam int IRQ_RX0 = 6;
  localparam int TICK_W = 24;

  // register byte addresses (low address byte)
  localparam logic [7:0] ADDR_RST_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_NMI_CAUSE = 8'h04;
  localparam logic [7:0] ADDR_SYS_CTRL = 8'h08;
  localparam logic [7:0] ADDR_PORT_IE = 8'h0C;
  localparam logic [7:0] ADDR_STBY_USE = 8'h10;
  localparam logic [7:0] ADDR_CG_MODE = 8'h14;
  localparam logic [7:0] ADDR_CG_FLAG = 8'h18;
  localparam logic [7:0] ADDR_SET_PEND = 8'h1C;
  localparam logic [7:0] ADDR_CLR_PEND = 8'h20;
  localparam logic [7:0] ADDR_TICK_CTRL = 8'h24;
  localparam logic [7:0] ADDR_TICK_RELOAD = 8'h28;
  localparam logic [7:0] ADDR_TICK_CURRENT = 8'h2C;
  localparam logic [7:0] ADDR_TICK_CALIB = 8'h30;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h34;

  // field positions
  localparam int SYS_SWRESET_BIT = 0;
  localparam int SYS_OSCILLATOR_SELECT_FIELD_BIT = 1;
  localparam int TICK_EN_BIT = 0;
  localparam int TICK_INT_BIT = 1;
  localparam int TICK_FLAG_BIT = 16;
  localparam int STAT_NUM_LSB = 24;
  localparam int STAT_VALID_BIT = 31;
  localparam int CG_MODE_W = 8;

  // reset values
  localparam logic [NUM_PINS-1:0] PORT_IE_RESET = 6'h00;
  localparam logic [NUM_IRQ-1:0] STBY_USE_RESET = 18'h00000;
  localparam logic [CG_MODE_W-1:0] CG_MODE_RESET = 8'h00;
  localparam logic [TICK_W-1:0] TICK_RELOAD_RESET = 24'h000000;
  localparam logic [31:0] BUS_ZERO = 32'h00000000;

  // lines that may use the standby release path: pins 1,2,4,5 and all peripherals
  localparam logic [NUM_IRQ-1:0] STBY_CAPABLE = 18'h3FFF6;

  // tick reference: selected oscillator over 32, calibration for 10 ms
  localparam int TICK_REF_DIV = 32;
  localparam int TICK_DIV_W = 5;
  localparam int TICK_PERIOD_MS = 10;
  localparam int MS_PER_S = 1000;
  localparam int unsigned OSC_FREQ_DEFAULT = 10000000;

  // standby detection mode per line: {edge, activeHigh}
  typedef enum logic [1:0] {
    MODE_LEVEL_LOW = 2'b00,
    MODE_LEVEL_HIGH = 2'b01,
    MODE_EDGE_FALL = 2'b10,
    MODE_EDGE_RISE = 2'b11
  } stby_mode_t;

  // reset causes, bit 5 down to bit 0
  typedef struct packed {
    logic sw;
    logic watchdog;
    logic freqDet;
    logic voltDet;
    logic por;
    logic pin;
  } reset_cause_t;

  // peripheral requests, packed so that {periph, pins} gives interrupt numbers 0..17
  typedef struct packed {
    logic convB;
    logic convA;
    logic ovv1;
    logic ovv0;
    logic emg1;
    logic emg0;
    logic vecB;
    logic vecA;
    logic tx1;
    logic rx1;
    logic tx0;
    logic rx0;
  } periph_irq_t;

  // latched ahb address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_phase_t;

endpackage : irq_route_pkg

// ### reset_nmi_irq_router.sv
// reset causes, nmi, system tick and interrupt routing with an ahb-lite register slave
`timescale 1ns/10ps
module reset_nmi_irq_router
  import irq_route_pkg::*;
#(
  parameter int unsigned OSC_FREQ_HZ = OSC_FREQ_DEFAULT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // reset sources
  input wire logic resetPin,
  input wire logic powerOnEvent,
  input wire logic voltDetectReq,
  input wire logic freqDetectReq,
  input wire logic watchdogResetReq,
  // nmi source
  input wire logic watchdogNmiReq,
  // interrupt sources
  input wire logic [NUM_PINS-1:0] extPinIrq,
  input wire periph_irq_t periphIrq,
  // oscillators for the tick reference
  input wire logic oscClkA,
  input wire logic oscClkB,
  // to the core
  output logic sysResetOut,
  output logic nmiToCore,
  output logic tickException,
  output logic [NUM_IRQ-1:0] irqToCore,
  output logic standbyRelease
);
  localparam logic [TICK_W-1:0] TICK_CALIB =
    TICK_W'(OSC_FREQ_HZ / TICK_REF_DIV * TICK_PERIOD_MS / MS_PER_S - 1);
  localparam int SYNC_W = NUM_PINS + 4;

  // lowest number wins: equal priority ties break toward the smaller number
  function automatic logic [IRQ_NUM_W-1:0] lowestSet(input logic [NUM_IRQ-1:0] v);
    logic [IRQ_NUM_W-1:0] n;
    n = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (v[i]) begin
        n = IRQ_NUM_W'(i);
      end
    end
    return n;
  endfunction : lowestSet

  // mode of a line: pins 1,2,4,5 own a slot, all else is high level
  function automatic stby_mode_t lineMode(input logic [CG_MODE_W-1:0] m, input int i);
    stby_mode_t r;
    case (i)
      1: r = stby_mode_t'(m[1:0]);
      2: r = stby_mode_t'(m[3:2]);
      4: r = stby_mode_t'(m[5:4]);
      5: r = stby_mode_t'(m[7:6]);
      default: r = MODE_LEVEL_HIGH;
    endcase
    return r;
  endfunction : lineMode

  function automatic logic stbyDetect(input logic lvl, input logic prev, input stby_mode_t md);
    logic r;
    case (md)
      MODE_LEVEL_LOW: r = !lvl;
      MODE_LEVEL_HIGH: r = lvl;
      MODE_EDGE_FALL: r = !lvl && prev;
      MODE_EDGE_RISE: r = lvl && !prev;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : stbyDetect

  // synchronised pins
  logic [SYNC_W-1:0] syncOut;
  logic [NUM_PINS-1:0] pinS;
  logic resetPinS;
  logic porS;
  logic oscAS;
  logic oscBS;

  sync2 #(.WIDTH(SYNC_W)) u_sync (
    .clk(ref_clk),
    .reset(reset),
    .async({oscClkB, oscClkA, powerOnEvent, resetPin, extPinIrq}),
    .synced(syncOut)
  );
  assign {oscBS, oscAS, porS, resetPinS, pinS} = syncOut;

  // bus state
  ahb_phase_t phase_r;
  logic wrEn;
  logic rdEn;
  logic [31:0] rdData;

  // software registers and previous levels for edge detection
  reset_cause_t resetCause_r;
  logic nmiCause_r;
  logic oscillator_select_field_r;
  logic [NUM_PINS-1:0] portIe_r;
  logic [NUM_IRQ-1:0] stbyUse_r;
  logic [CG_MODE_W-1:0] cgMode_r;
  logic [NUM_IRQ-1:0] cgFlag_r;
  logic [NUM_IRQ-1:0] forcedPend_r;
  logic tickEn_r;
  logic tickIntEn_r;
  logic countFlag_r;
  logic [TICK_W-1:0] tickReload_r;
  logic resetPinPrev_r;
  logic [NUM_IRQ-1:0] linePrev_r;

  // derived
  logic [NUM_PINS-1:0] pinLevel;
  logic [NUM_IRQ-1:0] lineLevel;
  logic [NUM_IRQ-1:0] useStby;
  logic [NUM_IRQ-1:0] cgDetect;
  logic [NUM_IRQ-1:0] edgeMode;
  logic [NUM_IRQ-1:0] routed;
  logic pinRise;
  logic swReq;
  reset_cause_t causeNow;
  logic [TICK_W-1:0] tickCurrent;
  logic tickZero;

  assign wrEn = phase_r.valid && phase_r.write;
  assign rdEn = hsel && htrans[1] && hready && !hwrite;

  // zero wait state slave, always okay; hsize is not checked, word access only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_r <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= BUS_ZERO;
    end else begin
      phase_r.valid <= hsel && htrans[1] && hready;
      phase_r.write <= hwrite;
      phase_r.addr <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rdEn) begin
        hrdata <= rdData;
      end
    end
  end

  always_comb begin
    rdData = BUS_ZERO;
    case (haddr[7:0])
      ADDR_RST_CAUSE: rdData = 32'(resetCause_r);
      ADDR_NMI_CAUSE: rdData = 32'(nmiCause_r);
      ADDR_SYS_CTRL: rdData[SYS_OSCILLATOR_SELECT_FIELD_BIT] = oscillator_select_field_r;
      ADDR_PORT_IE: rdData = 32'(portIe_r);
      ADDR_STBY_USE: rdData = 32'(stbyUse_r);
      ADDR_CG_MODE: rdData = 32'(cgMode_r);
      ADDR_CG_FLAG: rdData = 32'(cgFlag_r);
      ADDR_SET_PEND: rdData = 32'(forcedPend_r);
      ADDR_TICK_CTRL: begin
        rdData[TICK_EN_BIT] = tickEn_r;
        rdData[TICK_INT_BIT] = tickIntEn_r;
        rdData[TICK_FLAG_BIT] = countFlag_r;
      end
      ADDR_TICK_RELOAD: rdData = 32'(tickReload_r);
      ADDR_TICK_CURRENT: rdData = 32'(tickCurrent);
      ADDR_TICK_CALIB: rdData = 32'(TICK_CALIB);
      ADDR_IRQ_STATUS: begin
        rdData[NUM_IRQ-1:0] = irqToCore;
        rdData[STAT_NUM_LSB +: IRQ_NUM_W] = lowestSet(irqToCore);
        rdData[STAT_VALID_BIT] = |irqToCore;
      end
      default: rdData = BUS_ZERO;
    endcase
  end

  // control registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      oscillator_select_field_r <= 1'b0;
      portIe_r <= PORT_IE_RESET;
      stbyUse_r <= STBY_USE_RESET;
      cgMode_r <= CG_MODE_RESET;
      tickEn_r <= 1'b0;
      tickIntEn_r <= 1'b0;
      tickReload_r <= TICK_RELOAD_RESET;
    end else if (wrEn) begin
      case (phase_r.addr)
        ADDR_SYS_CTRL: oscillator_select_field_r <= hwdata[SYS_OSCILLATOR_SELECT_FIELD_BIT];
        ADDR_PORT_IE: portIe_r <= hwdata[NUM_PINS-1:0];
        ADDR_STBY_USE: stbyUse_r <= hwdata[NUM_IRQ-1:0];
        ADDR_CG_MODE: cgMode_r <= hwdata[CG_MODE_W-1:0];
        ADDR_TICK_CTRL: begin
          tickEn_r <= hwdata[TICK_EN_BIT];
          tickIntEn_r <= hwdata[TICK_INT_BIT];
        end
        ADDR_TICK_RELOAD: tickReload_r <= hwdata[TICK_W-1:0];
        default: tickEn_r <= tickEn_r;
      endcase
    end
  end

  // reset causes
  assign pinRise = resetPinS && !resetPinPrev_r;
  assign swReq = wrEn && phase_r.addr == ADDR_SYS_CTRL && hwdata[SYS_SWRESET_BIT];
  assign causeNow = '{sw: swReq, watchdog: watchdogResetReq, freqDet: freqDetectReq,
                      voltDet: voltDetectReq, por: porS, pin: pinRise};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      resetPinPrev_r <= 1'b0;
      sysResetOut <= 1'b0;
    end else begin
      resetPinPrev_r <= resetPinS;
      sysResetOut <= |causeNow;
    end
  end

  // no reset term: flags must outlive the system reset they cause; power-on defines them
  always_ff @(posedge ref_clk) begin
    if (porS) begin
      resetCause_r <= '{sw: 1'b0, watchdog: 1'b0, freqDet: 1'b0, voltDet: 1'b0, por: 1'b1,
                        pin: 1'b0};
    end else if (wrEn && phase_r.addr == ADDR_RST_CAUSE) begin
      resetCause_r <= (resetCause_r & ~reset_cause_t'(hwdata[5:0])) | causeNow;
    end else begin
      resetCause_r <= resetCause_r | causeNow;
    end
  end

  // nmi
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      nmiCause_r <= 1'b0;
      nmiToCore <= 1'b0;
    end else begin
      nmiToCore <= watchdogNmiReq;
      if (watchdogNmiReq) begin
        nmiCause_r <= 1'b1;
      end else if (wrEn && phase_r.addr == ADDR_NMI_CAUSE && hwdata[0]) begin
        nmiCause_r <= 1'b0;
      end
    end
  end

  // system tick
  sys_tick u_tick (
    .clk(ref_clk),
    .reset(reset),
    .oscLevel(oscillator_select_field_r ? oscBS : oscAS),
    .enable(tickEn_r),
    .reload(tickReload_r),
    .clearCurrent(wrEn && phase_r.addr == ADDR_TICK_CURRENT),
    .current(tickCurrent),
    .zeroPulse(tickZero)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      countFlag_r <= 1'b0;
      tickException <= 1'b0;
    end else begin
      tickException <= tickZero && tickIntEn_r;
      if (tickZero) begin
        countFlag_r <= 1'b1;
      end else if ((rdEn && haddr[7:0] == ADDR_TICK_CTRL) ||
                   (wrEn && phase_r.addr == ADDR_TICK_CURRENT)) begin
        countFlag_r <= 1'b0;
      end
    end
  end

  // interrupt lines
  assign pinLevel = pinS | ~portIe_r;
  assign lineLevel = {periphIrq, pinLevel};
  assign useStby = stbyUse_r & STBY_CAPABLE;

  always_comb begin
    for (int i = 0; i < NUM_IRQ; i++) begin
      cgDetect[i] = stbyDetect(lineLevel[i], linePrev_r[i], lineMode(cgMode_r, i));
      edgeMode[i] = lineMode(cgMode_r, i) inside {MODE_EDGE_FALL, MODE_EDGE_RISE};
    end
  end

  // edge flags hold until cleared, a new edge beats the clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      linePrev_r <= '0;
      cgFlag_r <= '0;
    end else begin
      linePrev_r <= lineLevel;
      for (int i = 0; i < NUM_IRQ; i++) begin
        if (!edgeMode[i]) begin
          cgFlag_r[i] <= cgDetect[i] && useStby[i];
        end else if (cgDetect[i] && useStby[i]) begin
          cgFlag_r[i] <= 1'b1;
        end else if (wrEn && phase_r.addr == ADDR_CG_FLAG && hwdata[i]) begin
          cgFlag_r[i] <= 1'b0;
        end
      end
    end
  end

  assign routed = (useStby & cgFlag_r) | (~useStby & lineLevel);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      forcedPend_r <= '0;
    end else if (wrEn && phase_r.addr == ADDR_SET_PEND) begin
      forcedPend_r <= forcedPend_r | hwdata[NUM_IRQ-1:0];
    end else if (wrEn && phase_r.addr == ADDR_CLR_PEND) begin
      forcedPend_r <= forcedPend_r & ~hwdata[NUM_IRQ-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irqToCore <= '0;
      standbyRelease <= 1'b0;
    end else begin
      irqToCore <= routed | forcedPend_r;
      standbyRelease <= |(useStby & cgFlag_r);
    end
  end

  default clocking cbMain @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_pin_rise;
    $rose(resetPinS) && !porS;
  endsequence

  sequence s_write_to(logic [7:0] a);
    wrEn && phase_r.addr == a;
  endsequence

  a_pin_rise_cause: assert property (s_pin_rise |=> resetCause_r.pin && sysResetOut)
    else $error("pin rise did not reset or record");

  a_sw_reset_req: assert property (
    s_write_to(ADDR_SYS_CTRL) ##0 hwdata[SYS_SWRESET_BIT] |=> sysResetOut && resetCause_r.sw)
    else $error("software reset request ignored");

  a_watchdog_reset_src: assert property (
    watchdogResetReq && !porS |=> resetCause_r.watchdog && sysResetOut)
    else $error("watchdog reset not taken");

  a_nmi_deliver: assert property (watchdogNmiReq |=> nmiToCore && nmiCause_r)
    else $error("watchdog nmi not delivered");

  a_tick_exception: assert property (tickZero && tickIntEn_r |=> tickException && countFlag_r)
    else $error("tick expiry not signalled");

  a_calib_read: assert property (rdEn && haddr[7:0] == ADDR_TICK_CALIB |=> hrdata == 32'(TICK_CALIB))
    else $error("calibration value wrong");

  a_input_disabled: assert property (!portIe_r[0] && !forcedPend_r[0] |=> irqToCore[0])
    else $error("disabled pin did not read high");

  a_direct_route: assert property (
    !useStby[IRQ_RX0] |=> irqToCore[IRQ_RX0] == $past(lineLevel[IRQ_RX0] | forcedPend_r[IRQ_RX0]))
    else $error("direct peripheral route broken");

  a_stby_route: assert property (
    useStby[1] |=> irqToCore[1] == $past(cgFlag_r[1] | forcedPend_r[1]))
    else $error("standby route broken");

  a_set_pending: assert property (
    s_write_to(ADDR_SET_PEND) |=> ##1 (irqToCore & $past(hwdata[NUM_IRQ-1:0], 2)) ==
      $past(hwdata[NUM_IRQ-1:0], 2))
    else $error("set-pending write did not force request");

endmodule : reset_nmi_irq_router

// ### sync2.sv
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // data
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      synced <= '0;
    end else begin
      meta_r <= async;
      synced <= meta_r;
    end
  end
endmodule : sync2

// ### sys_tick.sv
// system tick down counter with divided oscillator reference
`timescale 1ns/10ps
module sys_tick
  import irq_route_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // synchronised oscillator level, already selected
  input wire logic oscLevel,
  // control
  input wire logic enable,
  input wire logic [TICK_W-1:0] reload,
  input wire logic clearCurrent,
  // status
  output logic [TICK_W-1:0] current,
  output logic zeroPulse
);
  logic oscPrev_r;
  logic [TICK_DIV_W-1:0] div_r;
  logic refTick;

  always_ff @(posedge clk) begin
    if (reset) begin
      oscPrev_r <= 1'b0;
      div_r <= '0;
    end else begin
      oscPrev_r <= oscLevel;
      if (oscLevel && !oscPrev_r) begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  // one reference tick per 32 rising oscillator edges
  assign refTick = oscLevel && !oscPrev_r && (div_r == TICK_DIV_W'(TICK_REF_DIV - 1));

  always_ff @(posedge clk) begin
    if (reset) begin
      current <= '0;
      zeroPulse <= 1'b0;
    end else begin
      zeroPulse <= enable && refTick && (current == TICK_W'(1));
      if (clearCurrent) begin
        current <= '0;
      end else if (enable && refTick) begin
        if (current == '0) begin
          current <= reload;
        end else begin
          current <= current - 1'b1;
        end
      end
    end
  end

  default clocking cbTick @(posedge clk); endclocking
  default disable iff (reset);

  a_tick_load: assert property (
    enable && refTick && !clearCurrent && current == '0 |=> current == $past(reload))
    else $error("tick counter did not load reload value");

  a_tick_decrement: assert property (
    enable && refTick && !clearCurrent && current != '0 |=> current == $past(current) - 1'b1)
    else $error("tick counter did not decrement");

endmodule : sys_tick

// ### tb.sv
// self-checking bench for the reset, nmi, tick and interrupt router
`timescale 1ns/10ps
module tb;
  import irq_route_pkg::*;
  // osc a period in ref_clk cycles, b is twice that
  localparam int OSC_CYC = 8;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic resetPin = 1'b0;
  logic powerOnEvent = 1'b1;
  logic watchdogNmiReq = 1'b0;
  logic [2:0] src = 3'b000;
  logic [NUM_PINS-1:0] extPinIrq = 6'h00;
  periph_irq_t periphIrq = 12'h000;
  logic oscClkA = 1'b0;
  logic oscClkB = 1'b0;
  logic hreadyout, hresp, sysResetOut, nmiToCore, tickException, standbyRelease, svcValid;
  logic [31:0] hrdata;
  logic [NUM_IRQ-1:0] irqToCore;
  logic [IRQ_NUM_W-1:0] svcNum;
  int error_cnt = 0;
  int check_count = 0;
  int n;

  always #12.5 ref_clk = ~ref_clk;
  // osc edges never meet a rising ref_clk edge
  always #100 oscClkA = ~oscClkA;
  always #200 oscClkB = ~oscClkB;

  reset_nmi_irq_router i_reset_nmi_irq_router (
    .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .resetPin(resetPin),
    .powerOnEvent(powerOnEvent), .voltDetectReq(src[0]), .freqDetectReq(src[1]),
    .watchdogResetReq(src[2]), .watchdogNmiReq(watchdogNmiReq), .extPinIrq(extPinIrq),
    .periphIrq(periphIrq),
    .oscClkA(oscClkA), .oscClkB(oscClkB), .sysResetOut(sysResetOut),
    .nmiToCore(nmiToCore), .tickException(tickException), .irqToCore(irqToCore),
    .standbyRelease(standbyRelease)
  );
  core_irq_model i_core_irq_model (
    .ref_clk(ref_clk), .reset(reset), .irqToCore(irqToCore), .svcNum(svcNum),
    .svcValid(svcValid)
  );

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(string nm, logic [7:0] a, logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h00000000, q);
    chk(nm, q, exp);
  endtask : rdc
  task automatic cyc(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cyc
  // bounded so a dead tick shows up as a wrong gap
  task automatic tickGap(output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
    end while (tickException !== 1'b1 && c < 9000);
  endtask : tickGap
  task automatic test_done();
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  initial begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    // power-on must reach the synchronised side after reset to define the causes
    repeat (4) @(posedge ref_clk);
    powerOnEvent <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rdc("rstCause", ADDR_RST_CAUSE, 32'h00000002);
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk) src <= 3'b001 << k;
      @(posedge ref_clk) src <= 3'b000;
      #1 chk("sysResetOut", 32'(sysResetOut), 32'h00000001);
    end
    rdc("rstCause", ADDR_RST_CAUSE, 32'h0000001E);
    @(posedge ref_clk) resetPin <= 1'b1;
    cyc(6);
    rdc("rstCause", ADDR_RST_CAUSE, 32'h0000001F);
    wr(ADDR_SYS_CTRL, 32'h00000001);
    rdc("rstCause", ADDR_RST_CAUSE, 32'h0000003F);
    rdc("sysCtrl", ADDR_SYS_CTRL, 32'h00000000);
    // reset in mid-run must not lose the recorded causes
    @(posedge ref_clk) reset <= 1'b1;
    cyc(4);
    @(posedge ref_clk) reset <= 1'b0;
    rdc("rstCause", ADDR_RST_CAUSE, 32'h0000003F);
    wr(ADDR_RST_CAUSE, 32'h0000003F);
    rdc("rstCause", ADDR_RST_CAUSE, 32'h00000000);
    @(posedge ref_clk) watchdogNmiReq <= 1'b1;
    @(posedge ref_clk) watchdogNmiReq <= 1'b0;
    #1 chk("nmiToCore", 32'(nmiToCore), 32'h00000001);
    rdc("nmiCause", ADDR_NMI_CAUSE, 32'h00000001);
    wr(ADDR_NMI_CAUSE, 32'h00000001);
    rdc("nmiCause", ADDR_NMI_CAUSE, 32'h00000000);
    // period is reload plus one reference ticks; first gap of each osc discarded
    wr(ADDR_TICK_RELOAD, 32'h00000003);
    wr(ADDR_TICK_CTRL, 32'h00000003);
    for (int s = 1; s < 3; s++) begin
      tickGap(n);
      tickGap(n);
      chk("tickGap", 32'(n), 32'(4 * TICK_REF_DIV * OSC_CYC * s));
      rdc("tickCtrl", ADDR_TICK_CTRL, 32'h00010003);
      rdc("tickCtrl", ADDR_TICK_CTRL, 32'h00000003);
      wr(ADDR_SYS_CTRL, 32'h00000002);
    end
    wr(ADDR_TICK_CTRL, 32'h00000000);
    n = OSC_FREQ_DEFAULT / TICK_REF_DIV * TICK_PERIOD_MS / MS_PER_S - 1;
    rdc("calib", ADDR_TICK_CALIB, 32'(n));
    wr(ADDR_TICK_CALIB, 32'h00000000);
    rdc("calib", ADDR_TICK_CALIB, 32'(n));
    // disabled pin inputs read high and go straight through
    chk("irqToCore", 32'(irqToCore), 32'h0000003F);
    wr(ADDR_PORT_IE, 32'h0000003F);
    cyc(5);
    chk("irqToCore", 32'(irqToCore), 32'h00000000);
    for (int i = 0; i < NUM_IRQ; i++) begin
      @(posedge ref_clk) {periphIrq, extPinIrq} <= 18'h00001 << i;
      cyc(5);
      chk("irqToCore", 32'(irqToCore), 32'h1 << i);
      chk("svcNum", 32'(svcNum), 32'(i));
      rdc("status", ADDR_IRQ_STATUS, 32'h80000000 | (i << STAT_NUM_LSB) | (1 << i));
    end
    @(posedge ref_clk) {periphIrq, extPinIrq} <= 18'h00000;
    // release logic set up before use: pin 1 rising edge, pin 4 high level
    wr(ADDR_CG_MODE, 32'h00000013);
    wr(ADDR_STBY_USE, 32'h00000012);
    @(posedge ref_clk) extPinIrq <= 6'h02;
    cyc(6);
    @(posedge ref_clk) extPinIrq <= 6'h10;
    cyc(6);
    chk("irqToCore", 32'(irqToCore), 32'h00000012);
    chk("standbyRelease", 32'(standbyRelease), 32'h00000001);
    @(posedge ref_clk) extPinIrq <= 6'h00;
    wr(ADDR_CG_FLAG, 32'hFFFFFFFF);
    cyc(6);
    chk("irqToCore", 32'(irqToCore), 32'h00000000);
    chk("standbyRelease", 32'(standbyRelease), 32'h00000000);
    // pin 2 falling edge, pin 5 low level
    wr(ADDR_CG_MODE, 32'h00000008);
    wr(ADDR_STBY_USE, 32'h00000024);
    @(posedge ref_clk) extPinIrq <= 6'h24;
    cyc(6);
    wr(ADDR_CG_FLAG, 32'hFFFFFFFF);
    @(posedge ref_clk) extPinIrq <= 6'h00;
    cyc(6);
    chk("irqToCore", 32'(irqToCore), 32'h00000024);
    chk("standbyRelease", 32'(standbyRelease), 32'h00000001);
    @(posedge ref_clk) extPinIrq <= 6'h20;
    cyc(6);
    chk("irqToCore", 32'(irqToCore), 32'h00000004);
    wr(ADDR_CG_FLAG, 32'hFFFFFFFF);
    cyc(3);
    chk("irqToCore", 32'(irqToCore), 32'h00000000);
    wr(ADDR_SET_PEND, 32'h00020200);
    cyc(3);
    chk("irqToCore", 32'(irqToCore), 32'h00020200);
    chk("svcNum", 32'(svcNum), 32'h00000009);
    chk("svcValid", 32'(svcValid), 32'h00000001);
    rdc("setPend", ADDR_SET_PEND, 32'h00020200);
    wr(ADDR_CLR_PEND, 32'h0003FFFF);
    cyc(3);
    chk("irqToCore", 32'(irqToCore), 32'h00000000);
    rdc("unmapped", 8'h3C, 32'h00000000);
    chk("hresp", 32'(hresp), 32'h00000000);
    test_done();
  end
endmodule : tb
